// ===== rtl/vr_seq_cfg.svh
`ifndef VR_SEQ_CFG_SVH
`define VR_SEQ_CFG_SVH
// clock period in ns (25 MHz)
`define VR_CLK_NS 40
// soft-start delay before the ramp
`define VR_START_DELAY_US 100
`define VR_START_DELAY_CYC ((`VR_START_DELAY_US*1000+`VR_CLK_NS-1)/`VR_CLK_NS)
// reference slew: one dac step of 12.5 mV at 3.25 mV/us
`define VR_DAC_STEP_UV 12500
`define VR_SLEW_UV_PER_US 3250
`define VR_STEP_NS ((`VR_DAC_STEP_UV*1000)/`VR_SLEW_UV_PER_US)
`define VR_STEP_CYC (`VR_STEP_NS/`VR_CLK_NS)
// switch-node blanking after the low-side gate starts to fall
`define VR_BLANK_NS 20
`define VR_BLANK_CYC ((`VR_BLANK_NS+`VR_CLK_NS-1)/`VR_CLK_NS)
// high-side release delay at zero inductor current
`define VR_ZERO_DLY_NS 35
`define VR_ZERO_DLY_CYC ((`VR_ZERO_DLY_NS+`VR_CLK_NS-1)/`VR_CLK_NS)
// phase counts
`define VR_PHASES_2 3'h2
`define VR_PHASES_3 3'h3
`define VR_PHASES_4 3'h4
`endif

// ===== rtl/vr_seq_pkg.sv
package vr_seq_pkg;
	typedef enum logic [5:0] {
		SEQ_SHUTDOWN = 6'h01,
		SEQ_CHECK    = 6'h02,
		SEQ_DETECT   = 6'h04,
		SEQ_DELAY    = 6'h08,
		SEQ_RAMP     = 6'h10,
		SEQ_RUN      = 6'h20
	} seq_state_t;
	typedef enum logic [6:0] {
		DT_IDLE   = 7'h01,
		DT_LS_ON  = 7'h02,
		DT_BLANK  = 7'h04,
		DT_WAIT   = 7'h08,
		DT_DELAY  = 7'h10,
		DT_HS_ON  = 7'h20,
		DT_HS_OFF = 7'h40
	} dt_state_t;
endpackage

// ===== rtl/vr_init_and_vid_slew_control.sv
`timescale 1ns/10ps
`include "vr_seq_cfg.svh"
// Notes on behaviour
// - dac slews to target at fixed rate
// - high side released at direction-set threshold
// - zero current: high side after fixed delay
// - blank switch-node comparator after low-side fall
// - low side released on gate margin/phase low
// - soft-start needs enable, supplies, sense pins
// - output ok only when output in window
// - no operation before all three supplies ok
// - bias ok, then drivers, enable, detection
// - enable with hysteresis holds shutdown
// - mode latched on enable rising edge
// - sample sense pins before soft-start
// - only fourth pin high: three phases
// - both pins high: two phases
// - parallel mode: bridge regulator kept off
// - fixed delay then ramp at slew rate
module vr_init_and_vid_slew_control #(
	parameter int CODE_W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// supply and enable comparators
	input wire logic bias_por_ok,
	input wire logic core_driver_supply,
	input wire logic bridge_driver_supply,
	input wire logic en_above_rise,
	input wire logic en_above_fall,
	// strap and sense pins
	input wire logic mode_select_pin,
	input wire logic third_channel_sense_neg,
	input wire logic fourth_channel_sense_neg,
	// target code and output window
	input wire logic [CODE_W-1:0] target_level,
	input wire logic output_in_window,
	// dead-time comparators
	input wire logic pwm,
	input wire logic zero_current,
	input wire logic current_reverse,
	input wire logic phase_below_neg,
	input wire logic phase_above_pos,
	input wire logic phase_below_pos,
	input wire logic low_gate_below_half,
	input wire logic high_gate_margin_low,
	// gate drives
	output logic high_side_gate_drive,
	output logic low_side_gate_drive,
	// status
	output logic output_ok_flag,
	output logic parallel_code_mode,
	output logic serial_code_mode,
	output logic [2:0] phase_count,
	output logic bridge_enable,
	output logic [CODE_W-1:0] dac_level
);
	vr_seq_pkg::seq_state_t seq_reg;
	vr_seq_pkg::dt_state_t dt_reg, dt_next;
	logic enable_on_reg;
	logic all_por;
	logic running;
	logic [11:0] delay_cnt_reg;
	logic [6:0] step_cnt_reg;
	logic [1:0] dt_cnt_reg;
	logic [CODE_W-1:0] target_reg;
	logic thresh_hit;

	assign all_por = bias_por_ok && core_driver_supply && bridge_driver_supply;
	assign running = (seq_reg == vr_seq_pkg::SEQ_RAMP) ||
		(seq_reg == vr_seq_pkg::SEQ_RUN);

	// comparator hysteresis kept as a set/clear latch
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			enable_on_reg <= 1'b0;
		end else if (en_above_rise) begin
			enable_on_reg <= 1'b1;
		end else if (!en_above_fall) begin
			enable_on_reg <= 1'b0;
		end
	end

	// initialization sequencer
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			seq_reg <= vr_seq_pkg::SEQ_SHUTDOWN;
		end else if (!bias_por_ok) begin
			seq_reg <= vr_seq_pkg::SEQ_SHUTDOWN;
		end else begin
			case (seq_reg)
			vr_seq_pkg::SEQ_SHUTDOWN: begin
				seq_reg <= vr_seq_pkg::SEQ_CHECK;
			end
			vr_seq_pkg::SEQ_CHECK: begin
				if (all_por && enable_on_reg) begin
					seq_reg <= vr_seq_pkg::SEQ_DETECT;
				end
			end
			vr_seq_pkg::SEQ_DETECT: begin
				seq_reg <= vr_seq_pkg::SEQ_DELAY;
			end
			vr_seq_pkg::SEQ_DELAY: begin
				if (!all_por || !enable_on_reg) begin
					seq_reg <= vr_seq_pkg::SEQ_CHECK;
				end else if (delay_cnt_reg == 12'(`VR_START_DELAY_CYC - 1)) begin
					seq_reg <= vr_seq_pkg::SEQ_RAMP;
				end
			end
			vr_seq_pkg::SEQ_RAMP: begin
				if (!all_por || !enable_on_reg) begin
					seq_reg <= vr_seq_pkg::SEQ_CHECK;
				end else if (dac_level == target_reg) begin
					seq_reg <= vr_seq_pkg::SEQ_RUN;
				end
			end
			vr_seq_pkg::SEQ_RUN: begin
				if (!all_por || !enable_on_reg) begin
					seq_reg <= vr_seq_pkg::SEQ_CHECK;
				end
			end
			default: begin
				seq_reg <= vr_seq_pkg::SEQ_SHUTDOWN;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n || seq_reg != vr_seq_pkg::SEQ_DELAY) begin
			delay_cnt_reg <= 12'h000;
		end else begin
			delay_cnt_reg <= delay_cnt_reg + 12'h001;
		end
	end

	// mode and phases frozen until the sequencer drops back
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			parallel_code_mode <= 1'b0;
			serial_code_mode <= 1'b0;
			phase_count <= `VR_PHASES_4;
		end else if (seq_reg == vr_seq_pkg::SEQ_CHECK &&
			all_por && enable_on_reg && bias_por_ok) begin
			parallel_code_mode <= !mode_select_pin;
			serial_code_mode <= mode_select_pin;
		end else if (seq_reg == vr_seq_pkg::SEQ_DETECT) begin
			if (third_channel_sense_neg && fourth_channel_sense_neg) begin
				phase_count <= `VR_PHASES_2;
			end else if (fourth_channel_sense_neg) begin
				phase_count <= `VR_PHASES_3;
			end else begin
				phase_count <= `VR_PHASES_4;
			end
		end
	end

	// boot target taken once; live code tracked only once up, since
	// the processor sends only final codes and never steps itself
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			target_reg <= '0;
		end else if (seq_reg == vr_seq_pkg::SEQ_DETECT ||
			seq_reg == vr_seq_pkg::SEQ_RUN) begin
			target_reg <= target_level;
		end
	end

	// reference slew, one code step per step period
	always_ff @(posedge mclk) begin
		if (!reset_n || !running) begin
			dac_level <= '0;
			step_cnt_reg <= 7'h00;
		end else if (dac_level == target_reg) begin
			step_cnt_reg <= 7'h00;
		end else if (step_cnt_reg == 7'(`VR_STEP_CYC - 1)) begin
			step_cnt_reg <= 7'h00;
			if (dac_level < target_reg) begin
				dac_level <= dac_level + 1'b1;
			end else begin
				dac_level <= dac_level - 1'b1;
			end
		end else begin
			step_cnt_reg <= step_cnt_reg + 7'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			output_ok_flag <= 1'b0;
			bridge_enable <= 1'b0;
		end else begin
			output_ok_flag <= (seq_reg == vr_seq_pkg::SEQ_RUN) &&
				output_in_window;
			bridge_enable <= running && serial_code_mode;
		end
	end

	// dead-time control
	assign thresh_hit = current_reverse ? phase_above_pos : phase_below_neg;

	always_comb begin
		dt_next = dt_reg;
		case (dt_reg)
		vr_seq_pkg::DT_IDLE: begin
			if (!pwm) begin
				dt_next = vr_seq_pkg::DT_LS_ON;
			end
		end
		vr_seq_pkg::DT_LS_ON: begin
			if (pwm) begin
				dt_next = vr_seq_pkg::DT_BLANK;
			end
		end
		vr_seq_pkg::DT_BLANK: begin
			if (dt_cnt_reg == 2'(`VR_BLANK_CYC - 1)) begin
				dt_next = vr_seq_pkg::DT_WAIT;
			end
		end
		vr_seq_pkg::DT_WAIT: begin
			if (zero_current) begin
				if (low_gate_below_half) begin
					dt_next = vr_seq_pkg::DT_DELAY;
				end
			end else if (thresh_hit) begin
				dt_next = vr_seq_pkg::DT_HS_ON;
			end
		end
		vr_seq_pkg::DT_DELAY: begin
			if (dt_cnt_reg == 2'(`VR_ZERO_DLY_CYC - 1)) begin
				dt_next = vr_seq_pkg::DT_HS_ON;
			end
		end
		vr_seq_pkg::DT_HS_ON: begin
			if (!pwm) begin
				dt_next = vr_seq_pkg::DT_HS_OFF;
			end
		end
		vr_seq_pkg::DT_HS_OFF: begin
			if (high_gate_margin_low || phase_below_pos) begin
				dt_next = vr_seq_pkg::DT_LS_ON;
			end
		end
		default: begin
			dt_next = vr_seq_pkg::DT_IDLE;
		end
		endcase
		if (!running) begin
			dt_next = vr_seq_pkg::DT_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			dt_reg <= vr_seq_pkg::DT_IDLE;
			dt_cnt_reg <= 2'h0;
			high_side_gate_drive <= 1'b0;
			low_side_gate_drive <= 1'b0;
		end else begin
			dt_reg <= dt_next;
			dt_cnt_reg <= (dt_next == dt_reg) ? dt_cnt_reg + 2'h1 : 2'h0;
			high_side_gate_drive <= dt_next == vr_seq_pkg::DT_HS_ON;
			low_side_gate_drive <= dt_next == vr_seq_pkg::DT_LS_ON;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_por_before_start: assert property (
		(seq_reg == vr_seq_pkg::SEQ_DETECT) |->
			$past(all_por) && $past(enable_on_reg))
		else $error("soft-start entered without supplies or enable");
	a_mode_held: assert property (
		(running && $past(running)) |-> $stable(parallel_code_mode))
		else $error("code mode changed while running");
	a_phase_decode: assert property (
		(seq_reg == vr_seq_pkg::SEQ_DELAY &&
			$past(seq_reg) == vr_seq_pkg::SEQ_DETECT) |->
			phase_count == ($past(fourth_channel_sense_neg) ?
			($past(third_channel_sense_neg) ? 3'h2 : 3'h3) : 3'h4))
		else $error("phase count does not match sense pins");
	a_start_delay: assert property (
		(seq_reg == vr_seq_pkg::SEQ_RAMP &&
			$past(seq_reg) == vr_seq_pkg::SEQ_DELAY) |->
			$past(delay_cnt_reg) == 12'(`VR_START_DELAY_CYC - 1))
		else $error("ramp began before start delay ended");
	a_slew_period: assert property (
		(running && $past(running) && $changed(dac_level)) |->
			$past(step_cnt_reg) == 7'(`VR_STEP_CYC - 1))
		else $error("dac stepped off the slew period");
	a_hs_threshold: assert property (
		($rose(high_side_gate_drive) && $past(dt_reg) == vr_seq_pkg::DT_WAIT)
			|-> $past(thresh_hit) && !$past(zero_current))
		else $error("high side released before switch threshold");
	a_hs_zero_delay: assert property (
		(dt_reg == vr_seq_pkg::DT_DELAY &&
			$past(dt_reg) == vr_seq_pkg::DT_WAIT) |=>
			high_side_gate_drive || !running)
		else $error("zero-current release delay wrong");
	a_blanking: assert property (
		$rose(dt_reg == vr_seq_pkg::DT_BLANK) |->
			!high_side_gate_drive [*2])
		else $error("switch node watched inside blanking");
	a_ls_release: assert property (
		($rose(low_side_gate_drive) &&
			$past(dt_reg) == vr_seq_pkg::DT_HS_OFF) |->
			$past(high_gate_margin_low || phase_below_pos))
		else $error("low side released without condition");
	a_no_overlap: assert property (
		!(high_side_gate_drive && low_side_gate_drive))
		else $error("both gates on together");
	a_ok_window: assert property (
		output_ok_flag |-> $past(output_in_window) &&
			$past(seq_reg) == vr_seq_pkg::SEQ_RUN)
		else $error("output ok outside window");
	a_bridge_off: assert property (
		parallel_code_mode |=> !bridge_enable)
		else $error("bridge regulator on in parallel mode");
	a_enable_hyst: assert property (
		(enable_on_reg && en_above_fall) |=> enable_on_reg)
		else $error("enable dropped inside hysteresis");

	c_reach_run: cover property (seq_reg == vr_seq_pkg::SEQ_RUN);
	c_dac_step: cover property (running && $changed(dac_level));
	c_hs_zero: cover property (dt_reg == vr_seq_pkg::DT_DELAY);
	c_ok_set: cover property ($rose(output_ok_flag));
endmodule // vr_init_and_vid_slew_control

// ===== sim/vr_stage_model.sv
`timescale 1ns/10ps
module vr_stage_model (
	// clock
	input wire logic mclk,
	// gate drives and load current
	input wire logic high_side_gate_drive,
	input wire logic low_side_gate_drive,
	input wire logic zero_current,
	input wire logic current_reverse,
	// gate discharge time in cycles
	input wire logic [3:0] lag,
	// comparators
	output logic phase_below_neg,
	output logic phase_above_pos,
	output logic phase_below_pos,
	output logic low_gate_below_half,
	output logic high_gate_margin_low
);
	logic [3:0] lo_off_reg = 4'hf;
	logic [3:0] hi_off_reg = 4'hf;
	logic lo_done;
	logic hi_done;
	logic node_high;
	always_ff @(posedge mclk) begin
		lo_off_reg <= low_side_gate_drive ? 4'h0 :
			lo_off_reg + 4'(lo_off_reg != 4'hf);
		hi_off_reg <= high_side_gate_drive ? 4'h0 :
			hi_off_reg + 4'(hi_off_reg != 4'hf);
	end
	// node stays up until the high gate has really discharged
	always_comb begin
		lo_done = !low_side_gate_drive && lo_off_reg >= lag;
		hi_done = !high_side_gate_drive && hi_off_reg >= lag;
		node_high = high_side_gate_drive || (!low_side_gate_drive &&
			(!hi_done || (lo_done && current_reverse && !zero_current)));
		phase_above_pos = node_high;
		phase_below_pos = !node_high;
		phase_below_neg = !node_high && lo_done && !zero_current;
		low_gate_below_half = lo_done;
		high_gate_margin_low = hi_done;
	end
endmodule // vr_stage_model

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic mclk = 1'b0;
	logic reset_n, bias_por_ok, core_driver_supply, bridge_driver_supply;
	logic en_above_rise, en_above_fall, mode_select_pin, output_in_window;
	logic third_channel_sense_neg, fourth_channel_sense_neg;
	logic pwm, zero_current, current_reverse;
	logic phase_below_neg, phase_above_pos, phase_below_pos;
	logic low_gate_below_half, high_gate_margin_low;
	logic high_side_gate_drive, low_side_gate_drive, output_ok_flag;
	logic parallel_code_mode, serial_code_mode, bridge_enable;
	logic [2:0] phase_count;
	logic [7:0] target_level, dac_level;
	logic [7:0] dac_last = 8'h00;
	logic [3:0] lag;
	logic hi_q = 1'b0;
	logic lo_q = 1'b0;
	logic [1:0] hi_why = 2'b00;
	logic [1:0] lo_why = 2'b00;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int last_cyc = 0;
	int en_cyc = 0;
	int n;
	typedef struct {logic [7:0] lvl; int gap;} note_t;
	note_t dac_q[$];
	note_t nt;

	always #20 mclk = ~mclk;

	vr_init_and_vid_slew_control u_vr_init_and_vid_slew_control (.mclk,
		.reset_n, .bias_por_ok, .core_driver_supply, .bridge_driver_supply,
		.en_above_rise, .en_above_fall, .mode_select_pin,
		.third_channel_sense_neg, .fourth_channel_sense_neg, .target_level,
		.output_in_window, .pwm, .zero_current, .current_reverse,
		.phase_below_neg, .phase_above_pos, .phase_below_pos,
		.low_gate_below_half, .high_gate_margin_low, .high_side_gate_drive,
		.low_side_gate_drive, .output_ok_flag, .parallel_code_mode,
		.serial_code_mode, .phase_count, .bridge_enable, .dac_level);
	vr_stage_model u_vr_stage_model (.mclk, .high_side_gate_drive,
		.low_side_gate_drive, .zero_current, .current_reverse, .lag,
		.phase_below_neg, .phase_above_pos, .phase_below_pos,
		.low_gate_below_half, .high_gate_margin_low);

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic bound(input int lim);
		if (n >= lim) begin
			check(1'b0, "wait ran out");
			give_verdict();
		end
	endtask

	// a gate may only rise on a cause seen one or two cycles before
	always @(negedge mclk) begin
		cyc++;
		if (high_side_gate_drive === 1'b1 && !hi_q)
			check(!low_side_gate_drive &&
				hi_why != 2'b00, "high early");
		if (low_side_gate_drive === 1'b1 && !lo_q)
			check(!high_side_gate_drive &&
				lo_why != 2'b00, "low early");
		if (reset_n === 1'b1 && dac_level !== dac_last) begin
			if (dac_q.size() == 0) begin
				check(1'b0, "dac moved");
			end else begin
				nt = dac_q.pop_front();
				check(dac_level === nt.lvl, "dac level");
				if (nt.gap > 0)
					check(cyc - last_cyc == nt.gap, "step time");
				if (nt.gap < 0)
					check(cyc - en_cyc inside {[2500:2700]},
						"delay");
			end
			last_cyc = cyc;
		end
		dac_last = dac_level;
		hi_q = high_side_gate_drive;
		lo_q = low_side_gate_drive;
		hi_why = {hi_why[0], zero_current ? low_gate_below_half :
			current_reverse ? phase_above_pos : phase_below_neg};
		lo_why = {lo_why[0], high_gate_margin_low | phase_below_pos};
	end

	task automatic start_up(input logic sel, s3, s4, input logic [7:0] tgt,
			input logic [2:0] ph);
		@(negedge mclk);
		en_above_rise = 1'b0;
		en_above_fall = 1'b0;
		output_in_window = 1'b0;
		if (dac_level !== 8'h00) dac_q.push_back('{8'h00, 0});
		repeat (3) @(negedge mclk);
		check(output_ok_flag === 1'b0 &&
			dac_level === 8'h00, "off");
		mode_select_pin = sel;
		third_channel_sense_neg = s3;
		fourth_channel_sense_neg = s4;
		target_level = tgt;
		for (int i = 1; i <= tgt; i++) dac_q.push_back('{8'(i), i == 1 ? -1 : 96});
		// driver supplies are already up here
		en_above_rise = 1'b1;
		en_above_fall = 1'b1;
		en_cyc = cyc;
		for (n = 0; n < 4000 && dac_level !== tgt; n++) @(negedge mclk);
		bound(4000);
		check(phase_count === ph,
			"phases");
		check(serial_code_mode === sel &&
			parallel_code_mode === !sel, "mode");
		check(bridge_enable === sel, "bridge");
		repeat (5) @(negedge mclk);
		check(output_ok_flag === 1'b0, "ok out of window");
		output_in_window = 1'b1;
		repeat (3) @(negedge mclk);
		check(output_ok_flag === 1'b1, "ok missing");
		mode_select_pin = !sel;
		third_channel_sense_neg = !s3;
		fourth_channel_sense_neg = !s4;
		en_above_rise = 1'b0;
		repeat (4) @(negedge mclk);
		check(phase_count === ph &&
			serial_code_mode === sel &&
			output_ok_flag === 1'b1, "config moved");
	endtask

	task automatic vid_move(input logic [7:0] to);
		logic [7:0] v;
		int g;
		v = dac_level;
		g = 0;
		while (v != to) begin
			v = v < to ? v + 8'h01 : v - 8'h01;
			dac_q.push_back('{v, g});
			g = 96;
		end
		@(negedge mclk);
		target_level = to;
		for (n = 0; n < 2000 && dac_level !== to; n++) @(negedge mclk);
		bound(2000);
	endtask

	task automatic gate_run(input logic zc, rv, input logic [3:0] lg);
		@(negedge mclk);
		zero_current = zc;
		current_reverse = rv;
		lag = lg;
		pwm = 1'b1;
		for (n = 0; n < 40 && high_side_gate_drive !== 1'b1; n++) @(negedge mclk);
		bound(40);
		check(n >= (zc ? 4 : 3), "no blanking");
		repeat (2) @(negedge mclk);
		pwm = 1'b0;
		for (n = 0; n < 40 && low_side_gate_drive !== 1'b1; n++) @(negedge mclk);
		bound(40);
	endtask

	initial begin
		{reset_n, bias_por_ok, core_driver_supply, bridge_driver_supply} = '0;
		{en_above_rise, en_above_fall, mode_select_pin, output_in_window} = '0;
		{third_channel_sense_neg, fourth_channel_sense_neg} = '0;
		{pwm, zero_current, current_reverse} = '0;
		target_level = 8'h00;
		lag = 4'h0;
		void'($urandom(32'hfdd8));
		repeat (5) @(negedge mclk);
		reset_n = 1'b1;
		bias_por_ok = 1'b1;
		bridge_driver_supply = 1'b1;
		en_above_rise = 1'b1;
		en_above_fall = 1'b1;
		repeat (40) @(negedge mclk);
		check(output_ok_flag === 1'b0 &&
			serial_code_mode === 1'b0 &&
			parallel_code_mode === 1'b0, "ran unpowered");
		core_driver_supply = 1'b1;
		$display("test supply gating done");
		start_up(1'b0, 1'b0, 1'b0, 8'h04, 3'h4);
		start_up(1'b1, 1'b0, 1'b1, 8'h03, 3'h3);
		start_up(1'b0, 1'b1, 1'b1, 8'h05, 3'h2);
		start_up(1'b1, 1'b1, 1'b0, 8'h04, 3'h4);
		$display("test start-up done");
		for (int k = 0; k < 4; k++)
			vid_move(8'(1 + $urandom % 14));
		$display("test level change done");
		for (int k = 0; k < 6; k++)
			gate_run(k % 3 == 2, k % 3 == 1, k < 3 ? 4'h0 : 4'(1 + $urandom % 6));
		$display("test dead time done");
		@(negedge mclk);
		bias_por_ok = 1'b0;
		dac_q.push_back('{8'h00, 0});
		repeat (3) @(negedge mclk);
		check(output_ok_flag === 1'b0 &&
			dac_level === 8'h00, "bias loss");
		check(dac_q.size() == 0, "dac steps missing");
		$display("test bias loss done");
		give_verdict();
	end
endmodule // tb_top
